//--- hw/awfm_pkg.sv
// Summary of operation
// [RQ1] Current gain from gain bits two..zero
// [RQ2] Voltage gain from gain bits seven..five
// [RQ3] Software avoids unity current gain, dual inputs
// [RQ4] Converters powered down in battery, sleep
// [RQ5] Modulators sampled at master clock over five
// [RQ6] Decimator averages bit stream into 24-bit words
// [RQ7] Nominal full scale 0x20C49B, magnitude capped
// [RQ8] Current samples signed 24-bit, up to 25.6 kSPS
// [RQ9] Current sample spans scale with gain setting
// [RQ10] Voltage samples signed, smaller span, same rate
// [RQ11] Waveform bytes mapped at 0xE2 through 0xE7
// [RQ12] Billing datapath runs regardless of waveform reads
// [RQ13] Two-bit field selects waveform output rate
// [RQ14] Waveform-ready enable raises pending interrupt
// [RQ15] High-byte read latches samples into registers
// [RQ16] Interrupt held until ready flag cleared
// [RQ17] Fault when mismatch exceeds one sixteenth
// [RQ18] Fault with larger inactive input swaps input
// [RQ19] During fault bill from larger input
// [RQ20] Primary input used after power-up
// [RQ21] Fault reported after about one second
// [RQ22] Fault detection off below 0.3% voltage
// [RQ23] Ready flag is bit five, status high
// [RQ24] Fault-change flag plus enable raises interrupt
// [RQ25] Rate codes 00..11 give 25.6..3.2 kSPS
// [RQ26] Gain codes 000..100 valid, others reserved
package awfm_pkg;
  // Clocking and converter timing
  localparam int CLK_PERIOD_NS   = 8;
  localparam int CLK_KHZ         = 1000000 / CLK_PERIOD_NS;
  localparam int MCLK_KHZ        = 4096;
  localparam int MOD_DIV         = 5;
  localparam int WAVE_DIV        = 160;
  // Rate figure, so rounded down to whole system cycles
  localparam int MOD_TICK_CYCLES = (CLK_KHZ * MOD_DIV) / MCLK_KHZ;
  localparam int MOD_CNT_W       = 8;
  localparam int DECIM_RATIO     = WAVE_DIV / MOD_DIV;
  localparam int SAMPLE_RATE_HZ  = (MCLK_KHZ * 1000) / WAVE_DIV;
  localparam int FAULT_SECONDS   = 1;
  localparam int FAULT_SAMPLES   = SAMPLE_RATE_HZ * FAULT_SECONDS;
  localparam int FAULT_CNT_W     = 16;
  // Data scaling
  localparam int WORD_W          = 24;
  localparam int ACC_W           = 7;
  localparam int SCALE_SHIFT     = 17;
  localparam int VOLT_WAVE_SHIFT = 8;
  localparam int AVG_SHIFT       = 6;
  localparam int MISMATCH_SHIFT  = 4;
  localparam logic [23:0] FS_CODE  = 24'h20C49B;
  localparam logic [23:0] MAX_CODE = 24'h400000;
  localparam logic [23:0] VOLT_MIN = 24'((FS_CODE * 3) / 1000);
  // Register map
  localparam logic [7:0] ADDR_ENL    = 8'hD9;
  localparam logic [7:0] ADDR_ENH    = 8'hDB;
  localparam logic [7:0] ADDR_STL    = 8'hDC;
  localparam logic [7:0] ADDR_STH    = 8'hDE;
  localparam logic [7:0] ADDR_WAV1L  = 8'hE2;
  localparam logic [7:0] ADDR_WAV1M  = 8'hE3;
  localparam logic [7:0] ADDR_FIRST_SAMPLE_HIGH_BYTE  = 8'hE4;
  localparam logic [7:0] ADDR_WAV2L  = 8'hE5;
  localparam logic [7:0] ADDR_WAV2M  = 8'hE6;
  localparam logic [7:0] ADDR_SECOND_SAMPLE_HIGH_BYTE  = 8'hE7;
  localparam logic [7:0] ADDR_GAIN   = 8'hF1;
  localparam logic [7:0] ADDR_WAVCFG = 8'hF2;
  // Field positions and reset values
  localparam int WAVEFORM_READY_BIT      = 5;
  localparam int FAULT_BIT     = 5;
  localparam int CUR_GAIN_LSB  = 0;
  localparam int VOLT_GAIN_LSB = 5;
  localparam int RATE_LSB      = 0;
  localparam logic [7:0] REG_RST   = 8'h00;
  localparam logic [7:0] EN_MASK   = 8'h3F;
  localparam logic [2:0] GAIN_MAX  = 3'h4;
  localparam logic [2:0] GAIN_UNIT = 3'h0;

  // Fault monitor states
  typedef enum logic {AWFM_NORMAL, AWFM_FAULT} awfm_fault_t;

  // Reserved gain codes fall back to unity
  function automatic logic [2:0] awfm_gain_code(input logic [2:0] code);
    awfm_gain_code = (code > GAIN_MAX) ? GAIN_UNIT : code;
  endfunction
endpackage

//--- hw/awfm_dec_if.sv
`timescale 1ns/1ps
// Link between the top and one decimator channel
interface awfm_dec_if;
  logic        tick;    // Modulator sample strobe
  logic        clr;     // Hold filter cleared
  logic        bit_in;  // Modulator bit
  logic        valid;   // New word pulse
  logic [23:0] word;    // Signed output word
  modport dec (input tick, clr, bit_in, output valid, word);
  modport ctl (output tick, clr, bit_in, input valid, word);
endinterface

//--- hw/awfm_decim.sv
`timescale 1ns/1ps
// Boxcar decimator: averages the one-bit stream over a fixed window
module awfm_decim (
  input wire logic clock,
  input wire logic rst,
  awfm_dec_if.dec  d
);
  logic [awfm_pkg::MOD_CNT_W-1:0] cnt_q;  // Position in window
  logic signed [awfm_pkg::ACC_W-1:0] acc_q;  // Running +/-1 sum
  logic signed [awfm_pkg::ACC_W-1:0] sum;    // Sum including this bit
  logic [23:0] word_q;
  logic        valid_q;

  assign sum = acc_q + (d.bit_in ? 7'sh01 : -7'sh01);

  // Window accumulate; full window of +/-1 scales to the code limit
  always_ff @(posedge clock) begin
    if (rst || d.clr) begin
      cnt_q   <= '0;
      acc_q   <= '0;
      valid_q <= 1'b0;
      word_q  <= '0;
    end else begin
      valid_q <= 1'b0;
      if (d.tick) begin
        if (cnt_q == 8'(awfm_pkg::DECIM_RATIO - 1)) begin
          cnt_q   <= '0;
          acc_q   <= '0;
          word_q  <= {sum, 17'h00000};  // RQ6 RQ7
          valid_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 8'h01;
          acc_q <= sum;
        end
      end
    end
  end

  assign d.word  = word_q;
  assign d.valid = valid_q;

  property p_word_limit;
    @(posedge clock) disable iff (rst)
    valid_q |-> (word_q[23] ? (24'h0 - word_q) : word_q) <= awfm_pkg::MAX_CODE;
  endproperty
  a_word_limit: assert property (p_word_limit) else $error("word over limit"); // RQ7

  property p_word_spacing;
    @(posedge clock) disable iff (rst)
    valid_q |=> !valid_q [*8];
  endproperty
  a_word_spacing: assert property (p_word_spacing) else $error("words too close"); // RQ8
endmodule // awfm_decim

//--- hw/awfm_top.sv
`timescale 1ns/1ps
// Converter control, waveform registers and current fault monitor
module awfm_top #(
  parameter int FAULT_SAMPLES = awfm_pkg::FAULT_SAMPLES
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  input  wire logic        mod_cur_a_bit,
  input  wire logic        mod_cur_b_bit,
  input  wire logic        mod_volt_bit,
  input  wire logic        battery_power_state,
  input  wire logic        sleep_power_state,
  output logic             adc_power_down,
  output logic             mod_sample,
  output logic      [2:0]  current_amp_stage,
  output logic      [2:0]  volt_amp_stage,
  output logic             meter_irq,
  output logic             secondary_active,
  output logic             fault_active,
  output logic      [23:0] billing_current,
  output logic             billing_valid
);
  // Software registers
  logic [7:0]  gain_q;        // Amplifier gain select
  logic [7:0]  wavcfg_q;      // Waveform rate config
  logic [7:0]  enl_q;         // Enable low
  logic [7:0]  enh_q;         // Enable high
  logic        stl_fault_q;   // Fault change flag
  logic        sth_waveform_ready_q;    // Waveform ready flag
  logic [7:0]  rdata_q;
  logic        irq_q;
  // Converter side
  logic        pd_q;          // Converters powered down
  logic [7:0]  tick_cnt_q;
  logic        tick_q;
  logic [2:0]  cur_amp_q;
  logic [2:0]  volt_amp_q;
  logic [2:0]  mod_bits;
  logic [23:0] words [3];     // A, B, voltage
  logic        word_valid;
  // Waveform path
  logic [2:0]  rate_cnt_q;
  logic [3:0]  rate_div;
  logic        wave_take;
  logic [23:0] live1_q;       // Latest selected current
  logic [23:0] live2_q;       // Latest voltage
  logic [23:0] wav1_q;        // Latched first sample
  logic [23:0] wav2_q;        // Latched second sample
  // Fault monitor
  awfm_pkg::awfm_fault_t fstate_q;
  logic        active_b_q;
  logic [23:0] avg_a_q;
  logic [23:0] avg_b_q;
  logic [23:0] avg_v_q;
  logic [15:0] fcnt_q;
  logic [23:0] act_avg;
  logic [23:0] inact_avg;
  logic [23:0] diff_avg;
  logic        mismatch;
  logic        inact_larger;
  logic        volt_low;
  logic        swap_need;
  logic        change_need;
  logic [23:0] bill_q;
  logic        bill_valid_q;
  // Bus strobes
  logic        wr_stl;
  logic        wr_sth;
  logic        rd_h1;
  logic        rd_h2;

  // Rectify a signed word
  function automatic logic [23:0] mag(input logic [23:0] x);
    mag = x[23] ? (24'h000000 - x) : x;
  endfunction

  // First-order smoothing of a rectified level
  function automatic logic [23:0] avg_step(input logic [23:0] avg, input logic [23:0] x);
    logic signed [24:0] diff;
    diff     = $signed({1'b0, mag(x)}) - $signed({1'b0, avg});
    avg_step = 24'($signed({1'b0, avg}) + (diff >>> awfm_pkg::AVG_SHIFT));
  endfunction

  assign wr_stl = sfr_wr && (sfr_addr == awfm_pkg::ADDR_STL);
  assign wr_sth = sfr_wr && (sfr_addr == awfm_pkg::ADDR_STH);
  assign rd_h1  = sfr_rd && (sfr_addr == awfm_pkg::ADDR_FIRST_SAMPLE_HIGH_BYTE);
  assign rd_h2  = sfr_rd && (sfr_addr == awfm_pkg::ADDR_SECOND_SAMPLE_HIGH_BYTE);

  // Plain read/write registers; reserved enable bits stay zero
  always_ff @(posedge clock) begin
    if (rst) begin
      gain_q   <= awfm_pkg::REG_RST;
      wavcfg_q <= awfm_pkg::REG_RST;
      enl_q    <= awfm_pkg::REG_RST;
      enh_q    <= awfm_pkg::REG_RST;
    end else if (sfr_wr) begin
      unique case (sfr_addr)
        awfm_pkg::ADDR_GAIN:   gain_q   <= sfr_wdata;
        awfm_pkg::ADDR_WAVCFG: wavcfg_q <= sfr_wdata;
        awfm_pkg::ADDR_ENL:    enl_q    <= sfr_wdata & awfm_pkg::EN_MASK;
        awfm_pkg::ADDR_ENH:    enh_q    <= sfr_wdata & awfm_pkg::EN_MASK;
        default: ;  // Other addresses belong elsewhere
      endcase
    end
  end

  // Gain fields to the analog stages; reserved codes give unity
  always_ff @(posedge clock) begin
    if (rst) begin
      cur_amp_q  <= awfm_pkg::GAIN_UNIT;
      volt_amp_q <= awfm_pkg::GAIN_UNIT;
    end else begin
      cur_amp_q  <= awfm_pkg::awfm_gain_code(gain_q[awfm_pkg::CUR_GAIN_LSB +: 3]);  // RQ1 RQ26
      volt_amp_q <= awfm_pkg::awfm_gain_code(gain_q[awfm_pkg::VOLT_GAIN_LSB +: 3]); // RQ2 RQ26
    end
  end

  // Power states shut the converters; filters are held cleared
  always_ff @(posedge clock) begin
    if (rst) begin
      pd_q <= 1'b0;
    end else begin
      pd_q <= battery_power_state || sleep_power_state;  // RQ4
    end
  end

  // Modulator sample strobe at master clock over five
  always_ff @(posedge clock) begin
    if (rst || pd_q) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == 8'(awfm_pkg::MOD_TICK_CYCLES - 1)) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b1;  // RQ5
    end else begin
      tick_cnt_q <= tick_cnt_q + 8'h01;
      tick_q     <= 1'b0;
    end
  end

  // Three decimator channels share timing, so one valid serves all
  assign mod_bits = {mod_volt_bit, mod_cur_b_bit, mod_cur_a_bit};
  awfm_dec_if dif [3] ();
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_ch
      assign dif[gi].tick   = tick_q;
      assign dif[gi].clr    = pd_q;
      assign dif[gi].bit_in = mod_bits[gi];
      assign words[gi]      = dif[gi].word;
      awfm_decim u_dec (
        .clock (clock),
        .rst   (rst),
        .d     (dif[gi].dec)
      );
    end
  endgenerate
  assign word_valid = dif[0].valid;

  // Rate select keeps one word in 1, 2, 4 or 8
  assign rate_div  = 4'h1 << wavcfg_q[awfm_pkg::RATE_LSB +: 2];              // RQ25
  assign wave_take = word_valid && (rate_cnt_q == 3'(rate_div - 4'h1));      // RQ13

  always_ff @(posedge clock) begin
    if (rst) begin
      rate_cnt_q <= '0;
    end else if (wave_take) begin
      rate_cnt_q <= '0;
    end else if (word_valid) begin
      rate_cnt_q <= rate_cnt_q + 3'h1;
    end
  end

  // Live samples: measured current and voltage at reduced span
  always_ff @(posedge clock) begin
    if (rst) begin
      live1_q <= '0;
      live2_q <= '0;
    end else if (wave_take) begin
      live1_q <= active_b_q ? words[1] : words[0];                      // RQ8 RQ9
      live2_q <= 24'($signed(words[2]) >>> awfm_pkg::VOLT_WAVE_SHIFT);  // RQ10
    end
  end

  // Reading a high byte freezes both samples for the byte reads after it
  always_ff @(posedge clock) begin
    if (rst) begin
      wav1_q <= '0;
      wav2_q <= '0;
    end else if (rd_h1 || rd_h2) begin
      wav1_q <= live1_q;  // RQ15
      wav2_q <= live2_q;  // RQ15
    end
  end

  // Status flags: a new event in the clearing cycle wins
  always_ff @(posedge clock) begin
    if (rst) begin
      sth_waveform_ready_q  <= 1'b0;
      stl_fault_q <= 1'b0;
    end else begin
      if (wave_take) begin
        sth_waveform_ready_q <= 1'b1;  // RQ23
      end else if (wr_sth && !sfr_wdata[awfm_pkg::WAVEFORM_READY_BIT]) begin
        sth_waveform_ready_q <= 1'b0;  // RQ16
      end
      if (change_need && fcnt_q == 16'(FAULT_SAMPLES - 1) && word_valid && !volt_low) begin
        stl_fault_q <= 1'b1;
      end else if (wr_stl && !sfr_wdata[awfm_pkg::FAULT_BIT]) begin
        stl_fault_q <= 1'b0;
      end
    end
  end

  // Pending interrupt stays while an enabled flag is set
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (sth_waveform_ready_q && enh_q[awfm_pkg::WAVEFORM_READY_BIT])    // RQ14 RQ16
            || (stl_fault_q && enl_q[awfm_pkg::FAULT_BIT]);  // RQ24
    end
  end

  // Registered read data; unmapped addresses read zero
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (sfr_rd) begin
      unique case (sfr_addr)
        awfm_pkg::ADDR_GAIN:   rdata_q <= gain_q;
        awfm_pkg::ADDR_WAVCFG: rdata_q <= wavcfg_q;
        awfm_pkg::ADDR_ENL:    rdata_q <= enl_q;
        awfm_pkg::ADDR_ENH:    rdata_q <= enh_q;
        awfm_pkg::ADDR_STL:    rdata_q <= {2'h0, stl_fault_q, 5'h00};
        awfm_pkg::ADDR_STH:    rdata_q <= {2'h0, sth_waveform_ready_q, 5'h00};
        awfm_pkg::ADDR_WAV1L:  rdata_q <= wav1_q[7:0];    // RQ11
        awfm_pkg::ADDR_WAV1M:  rdata_q <= wav1_q[15:8];
        awfm_pkg::ADDR_FIRST_SAMPLE_HIGH_BYTE:  rdata_q <= live1_q[23:16];
        awfm_pkg::ADDR_WAV2L:  rdata_q <= wav2_q[7:0];
        awfm_pkg::ADDR_WAV2M:  rdata_q <= wav2_q[15:8];
        awfm_pkg::ADDR_SECOND_SAMPLE_HIGH_BYTE:  rdata_q <= live2_q[23:16]; // RQ11
        default:               rdata_q <= 8'h00;
      endcase
    end
  end

  // Smoothed input levels; the long hold count does the rest
  always_ff @(posedge clock) begin
    if (rst) begin
      avg_a_q <= '0;
      avg_b_q <= '0;
      avg_v_q <= '0;
    end else if (word_valid) begin
      avg_a_q <= avg_step(avg_a_q, words[0]);
      avg_b_q <= avg_step(avg_b_q, words[1]);
      avg_v_q <= avg_step(avg_v_q, words[2]);
    end
  end

  assign act_avg      = active_b_q ? avg_b_q : avg_a_q;
  assign inact_avg    = active_b_q ? avg_a_q : avg_b_q;
  assign inact_larger = inact_avg > act_avg;
  assign diff_avg     = inact_larger ? (inact_avg - act_avg) : (act_avg - inact_avg);
  assign mismatch     = diff_avg > (act_avg >> awfm_pkg::MISMATCH_SHIFT);  // RQ17
  assign volt_low     = avg_v_q < awfm_pkg::VOLT_MIN;                      // RQ22
  assign swap_need    = mismatch && inact_larger;                           // RQ18
  assign change_need  = swap_need
                     || (mismatch != (fstate_q == awfm_pkg::AWFM_FAULT));

  // Condition must hold for about a second of samples before acting;
  // a low voltage level stops the monitor so noise cannot trip it
  always_ff @(posedge clock) begin
    if (rst) begin
      fcnt_q     <= '0;
      fstate_q   <= awfm_pkg::AWFM_NORMAL;
      active_b_q <= 1'b0;  // RQ20
    end else if (word_valid) begin
      if (volt_low || !change_need) begin
        fcnt_q <= '0;  // RQ22
      end else if (fcnt_q == 16'(FAULT_SAMPLES - 1)) begin
        fcnt_q   <= '0;  // RQ21
        fstate_q <= mismatch ? awfm_pkg::AWFM_FAULT : awfm_pkg::AWFM_NORMAL;
        if (swap_need) begin
          active_b_q <= !active_b_q;  // RQ18 RQ19
        end
      end else begin
        fcnt_q <= fcnt_q + 16'h0001;
      end
    end
  end

  // Billing current keeps flowing whatever the waveform reads do
  always_ff @(posedge clock) begin
    if (rst) begin
      bill_q       <= '0;
      bill_valid_q <= 1'b0;
    end else begin
      bill_valid_q <= word_valid;  // RQ12
      if (word_valid) begin
        bill_q <= active_b_q ? words[1] : words[0];  // RQ19
      end
    end
  end

  assign sfr_rdata         = rdata_q;
  assign adc_power_down    = pd_q;
  assign mod_sample        = tick_q;
  assign current_amp_stage = cur_amp_q;
  assign volt_amp_stage    = volt_amp_q;
  assign meter_irq         = irq_q;
  assign secondary_active  = active_b_q;
  assign fault_active      = (fstate_q == awfm_pkg::AWFM_FAULT);
  assign billing_current   = bill_q;
  assign billing_valid     = bill_valid_q;

  property p_cur_gain;
    @(posedge clock) disable iff (rst)
    (gain_q[2:0] == 3'h3) ##1 $stable(gain_q) |-> cur_amp_q == 3'h3;
  endproperty
  a_cur_gain: assert property (p_cur_gain) else $error("current gain not applied"); // RQ1

  property p_volt_gain;
    @(posedge clock) disable iff (rst)
    (gain_q[7:5] > 3'h4) ##1 $stable(gain_q) |-> volt_amp_q == 3'h0;
  endproperty
  a_volt_gain: assert property (p_volt_gain) else $error("reserved gain not unity"); // RQ2

  property p_power_down;
    @(posedge clock) disable iff (rst)
    (battery_power_state || sleep_power_state) |=> pd_q ##1 !word_valid;
  endproperty
  a_power_down: assert property (p_power_down) else $error("converter not down"); // RQ4

  property p_waveform_ready_set;
    @(posedge clock) disable iff (rst)
    wave_take |=> sth_waveform_ready_q ##1 (irq_q || !$past(enh_q[awfm_pkg::WAVEFORM_READY_BIT]));
  endproperty
  a_waveform_ready_set: assert property (p_waveform_ready_set) else $error("ready flag or irq missing"); // RQ23

  property p_irq_hold;
    @(posedge clock) disable iff (rst)
    (sth_waveform_ready_q && enh_q[5]) [*2] |-> irq_q;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped early"); // RQ16

  property p_fault_irq;
    @(posedge clock) disable iff (rst)
    (stl_fault_q && enl_q[5]) |=> irq_q;
  endproperty
  a_fault_irq: assert property (p_fault_irq) else $error("fault irq missing"); // RQ24

  property p_latch;
    @(posedge clock) disable iff (rst)
    rd_h1 |=> (wav1_q == $past(live1_q)) && (wav2_q == $past(live2_q));
  endproperty
  a_latch: assert property (p_latch) else $error("samples not latched"); // RQ15

  property p_primary_first;
    @(posedge clock) disable iff (rst)
    $past(rst) |-> !active_b_q && fstate_q == awfm_pkg::AWFM_NORMAL;
  endproperty
  a_primary_first: assert property (p_primary_first) else $error("not primary at start"); // RQ20

  property p_low_volt;
    @(posedge clock) disable iff (rst)
    (word_valid && volt_low) |=> fcnt_q == 16'h0000 && $stable(active_b_q);
  endproperty
  a_low_volt: assert property (p_low_volt) else $error("fault monitor ran at low voltage"); // RQ22
endmodule // awfm_top

//--- dv/awfm_core_model.sv
`timescale 1ns/1ps
// Core model: one-cycle register strobes, read data taken a cycle later
module awfm_core_model (
  input  wire logic       clock,
  output logic      [7:0] sfr_addr,
  output logic            sfr_wr,
  output logic            sfr_rd,
  output logic      [7:0] sfr_wdata,
  input  wire logic [7:0] sfr_rdata
);
  // Idle bus at time zero
  initial begin
    sfr_addr  = 8'h00;
    sfr_wr    = 1'b0;
    sfr_rd    = 1'b0;
    sfr_wdata = 8'h00;
  end
  // Write stands one edge; data then inverted so nothing stale lingers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge clock);
    sfr_wr    <= 1'b0;
    sfr_wdata <= ~d;
  endtask
  // Read data is registered, so it is taken just after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge clock);
    sfr_rd   <= 1'b0;
    #1;
    d = sfr_rdata;
  endtask
endmodule // awfm_core_model

//--- dv/awfm_top_tb.sv
`timescale 1ns/1ps
// Bench for gain, waveform registers, rate, fault swap and power down
module awfm_top_tb;
  localparam int FS    = 4;       // Short fault persistence keeps the run brief
  localparam int LIMIT = 90000;   // About sixteen words plus margin; beyond is a hang
  logic        clock, rst, a_tog; // Clock, reset, primary toggle mode
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, rv;
  logic        sfr_wr, sfr_rd, mod_cur_a_bit, mod_cur_b_bit, mod_volt_bit;
  logic        battery_power_state, sleep_power_state, adc_power_down;
  logic        mod_sample, meter_irq, secondary_active, fault_active, billing_valid;
  logic [2:0]  current_amp_stage, volt_amp_stage;
  logic [23:0] billing_current;
  int          err_total, checks, cyc, n, r, k;

  awfm_core_model core (.clock(clock), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));
  awfm_top #(.FAULT_SAMPLES(FS)) dut (.clock(clock), .rst(rst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .mod_cur_a_bit(mod_cur_a_bit), .mod_cur_b_bit(mod_cur_b_bit),
    .mod_volt_bit(mod_volt_bit), .battery_power_state(battery_power_state),
    .sleep_power_state(sleep_power_state), .adc_power_down(adc_power_down),
    .mod_sample(mod_sample), .current_amp_stage(current_amp_stage),
    .volt_amp_stage(volt_amp_stage), .meter_irq(meter_irq),
    .secondary_active(secondary_active), .fault_active(fault_active),
    .billing_current(billing_current), .billing_valid(billing_valid));

  // Half-period inversion gives 125 MHz
  always #4 clock = ~clock;
  // Alternating bits average to zero, so the primary input fades
  always @(posedge clock) if (a_tog && mod_sample) mod_cur_a_bit <= ~mod_cur_a_bit;
  // Hang guard: counts as a mismatch
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total = err_total + 1;
      tally_and_finish();
    end
  end

  // Step past an edge so its updates have landed
  task automatic tick;
    @(posedge clock);
    #1;
  endtask
  // Single comparison point
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Register read compared with an expected byte
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    core.rd(a, rv);
    check($sformatf("sfr_%h", a), 24'(rv), 24'(e));
  endtask
  // Wait for the interrupt, counting converter words meanwhile
  task automatic wait_irq(output int bv);
    bv = 0;
    do begin
      tick();
      if (billing_valid === 1'b1) bv++;
    end while (meter_irq !== 1'b1);
  endtask
  // Clear the ready flag and let the interrupt fall
  task automatic clr_wave;
    core.wr(awfm_pkg::ADDR_STH, 8'h00);
    repeat (3) tick();
  endtask
  // Verdict
  task automatic tally_and_finish;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    rst = 1'b1;
    a_tog = 1'b0;
    cyc = 0;
    err_total = 0;
    checks = 0;
    mod_cur_a_bit = 1'b1;
    mod_cur_b_bit = 1'b1;
    mod_volt_bit = 1'b0;
    battery_power_state = 1'b0;
    sleep_power_state = 1'b0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    tick();
    check("sec_act", 24'(secondary_active), 24'h0);
    rchk(awfm_pkg::ADDR_GAIN, 8'h00);
    rchk(8'h80, 8'h00);
    // Every gain code on both fields; reserved codes fall to unity
    for (n = 0; n < 8; n++) begin
      core.wr(awfm_pkg::ADDR_GAIN, {n[2:0], 2'h0, n[2:0]});
      repeat (2) tick();
      k = (n > 4) ? 0 : n;
      check("cur_gain", 24'(current_amp_stage), 24'(k));
      check("volt_gain", 24'(volt_amp_stage), 24'(k));
    end
    core.wr(awfm_pkg::ADDR_GAIN, 8'h21);
    core.wr(awfm_pkg::ADDR_ENH, 8'hFF);
    rchk(awfm_pkg::ADDR_ENH, 8'h3F);
    core.wr(awfm_pkg::ADDR_ENH, 8'h20);
    // Modulator strobe spacing
    while (mod_sample !== 1'b1) tick();
    n = 0;
    do begin
      tick();
      n++;
    end while (mod_sample !== 1'b1);
    check("mod_period", 24'(n), 24'(awfm_pkg::MOD_TICK_CYCLES));
    // Full-scale streams: current all ones, voltage all zeros
    wait_irq(n);
    check("bill", billing_current, 24'h400000);
    rchk(awfm_pkg::ADDR_STH, 8'h20);
    rchk(awfm_pkg::ADDR_FIRST_SAMPLE_HIGH_BYTE, 8'h40);
    rchk(awfm_pkg::ADDR_WAV1M, 8'h00);
    rchk(awfm_pkg::ADDR_WAV1L, 8'h00);
    rchk(awfm_pkg::ADDR_SECOND_SAMPLE_HIGH_BYTE, 8'hFF);
    rchk(awfm_pkg::ADDR_WAV2M, 8'hC0);
    rchk(awfm_pkg::ADDR_WAV2L, 8'h00);
    check("irq_held", 24'(meter_irq), 24'h1);
    clr_wave();
    check("irq_clr", 24'(meter_irq), 24'h0);
    // Rates run while the primary fades and the monitor works
    a_tog <= 1'b1;
    for (r = 0; r < 3; r++) begin
      core.wr(awfm_pkg::ADDR_WAVCFG, 8'(r));
      clr_wave();
      wait_irq(n);
      clr_wave();
      wait_irq(n);
      check("rate_words", 24'(n), 24'(1 << r));
      // Mismatch has held for only one word here, short of the persistence count
      if (r == 0) check("fault_early", 24'(fault_active), 24'h0);
    end
    core.wr(awfm_pkg::ADDR_WAVCFG, 8'h03);
    rchk(awfm_pkg::ADDR_WAVCFG, 8'h03);
    check("fault", 24'(fault_active), 24'h1);
    check("sec_act", 24'(secondary_active), 24'h1);
    do tick(); while (billing_valid !== 1'b1);
    check("bill_sec", billing_current, 24'h400000);
    // Fault flag drives the interrupt only through its enable
    core.wr(awfm_pkg::ADDR_ENH, 8'h00);
    core.wr(awfm_pkg::ADDR_ENL, 8'h20);
    repeat (3) tick();
    check("irq_fault", 24'(meter_irq), 24'h1);
    rchk(awfm_pkg::ADDR_STL, 8'h20);
    core.wr(awfm_pkg::ADDR_STL, 8'h00);
    repeat (3) tick();
    check("irq_fclr", 24'(meter_irq), 24'h0);
    // Battery then sleep: converters off, no modulator strobes
    for (n = 0; n < 2; n++) begin
      @(posedge clock);
      battery_power_state <= (n == 0);
      sleep_power_state   <= (n == 1);
      repeat (2) tick();
      check("pwr_down", 24'(adc_power_down), 24'h1);
      k = 0;
      repeat (200) begin
        tick();
        if (mod_sample !== 1'b0) k++;
      end
      check("idle_strobes", 24'(k), 24'h0);
      @(posedge clock);
      battery_power_state <= 1'b0;
      sleep_power_state   <= 1'b0;
    end
    repeat (3) tick();
    check("pwr_up", 24'(adc_power_down), 24'h0);
    tally_and_finish();
  end
endmodule // awfm_top_tb
